/* File: epl_regs.vh */
`ifndef EPL_REGS_VH
`define EPL_REGS_VH

// register offsets on the device register port
`define EPL_ADDR_MEM_READY   8'hF0
`define EPL_ADDR_PAGE_LO     8'hF1
`define EPL_ADDR_PAGE_HI     8'hF2
`define EPL_ADDR_BUF_PORT    8'hF3
`define EPL_ADDR_MEM_CMD     8'hF4
`define EPL_ADDR_SRST_LOAD   8'hF8
`define EPL_ADDR_LOAD_CRC    8'hF9

// page index field and page geometry
`define EPL_PAGE_MSB         14
`define EPL_PAGE_LSB         6
`define EPL_PAGE_BYTES       7'h40
`define EPL_HALF_PAGE        7'h20
`define EPL_BOOT_PAGE        9'h000

// memory command codes
`define EPL_CMD_PTR_RST      2'h0
`define EPL_CMD_LOAD         2'h1
`define EPL_CMD_BURN         2'h2
`define EPL_CMD_RSVD         2'h3

// soft reset key and reset values
`define EPL_SRST_KEY         8'hA5
`define EPL_PAGE_IDX_RST     16'h0000
`define EPL_CMD_RST          2'h0

// serial engine commands
`define EPL_LNK_START        2'h0
`define EPL_LNK_STOP         2'h1
`define EPL_LNK_WRITE        2'h2
`define EPL_LNK_READ         2'h3

// timing: clock period, link quarter bit, write cycle time
`define EPL_CLK_NS           10
`define EPL_QTR_NS           2500
`define EPL_QTR_CYC          ((`EPL_QTR_NS + `EPL_CLK_NS - 1) / `EPL_CLK_NS)
`define EPL_TWR_NS           5000000
`define EPL_TWR_CYC          ((`EPL_TWR_NS + `EPL_CLK_NS - 1) / `EPL_CLK_NS)

// serial address of the memory, arbitrary default
`define EPL_DEV_ADDR         7'h50

`endif

/* File: epl_fifo.v */
`timescale 1ns/1ps
module epl_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             ref_clk_i,
	input  wire             rst_n_i,
	input  wire             ce_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o,
	output wire [AW:0]      level_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_ff;
	reg [AW-1:0]    rp_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	// full and empty come from the stored count only
	assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_o  = mem[rp_ff];
	assign level_o     = cnt_ff;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage has no reset, pointers do
	always @(posedge ref_clk_i)
	begin
		if (ce_i && push)
			mem[wp_ff] <= in_data_i;
	end

	// pointer and level bookkeeping, wraps at DEPTH
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			wp_ff  <= {AW{1'b0}};
			rp_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end
		else if (ce_i)
		begin
			if (push)
				wp_ff <= (wp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
			if (pop)
				rp_ff <= (rp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule

/* File: epl_link.v */
`timescale 1ns/1ps
`include "epl_regs.vh"
module epl_link #(
	parameter QTR_CYC = `EPL_QTR_CYC,
	parameter CW      = 12
) (
	input  wire       ref_clk_i,
	input  wire       rst_n_i,
	input  wire       ce_i,
	input  wire       cmd_valid_i,
	input  wire [1:0] cmd_i,
	input  wire [7:0] din_i,
	input  wire       mack_i,
	output wire       busy_o,
	output reg        done_o,
	output wire [7:0] dout_o,
	output reg        scl_o,
	output wire       sda_o,
	output reg        sda_oe_o,
	input  wire       sda_i
);
	localparam [3:0] L_IDLE  = 4'b0001;
	localparam [3:0] L_START = 4'b0010;
	localparam [3:0] L_BYTE  = 4'b0100;
	localparam [3:0] L_STOP  = 4'b1000;
	localparam [3:0] ACK_BIT = 4'h8;

	reg [3:0]    st_ff;
	reg [1:0]    q_ff;
	reg [CW-1:0] tcnt_ff;
	reg [3:0]    bit_ff;
	reg [7:0]    sh_ff;
	reg          rd_ff;
	reg          mack_ff;
	reg          sda_meta_ff;
	reg          sda_s_ff;
	wire         tick;

	// open drain: the pin is only ever pulled low
	assign sda_o  = 1'b0;
	assign busy_o = (st_ff != L_IDLE);
	assign dout_o = sh_ff;
	assign tick   = (tcnt_ff == QTR_CYC[CW-1:0] - 1'b1);

	// data pin comes from outside, two flops before use
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			sda_meta_ff <= 1'b1;
			sda_s_ff    <= 1'b1;
		end
		else if (ce_i)
		begin
			sda_meta_ff <= sda_i;
			sda_s_ff    <= sda_meta_ff;
		end
	end

	// quarter-bit sequencer; scl derived from ref_clk_i by division
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			st_ff    <= L_IDLE;
			q_ff     <= 2'h0;
			tcnt_ff  <= {CW{1'b0}};
			bit_ff   <= 4'h0;
			sh_ff    <= 8'h00;
			rd_ff    <= 1'b0;
			mack_ff  <= 1'b0;
			done_o   <= 1'b0;
			scl_o    <= 1'b1;
			sda_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			done_o  <= 1'b0;
			tcnt_ff <= (busy_o && !tick) ? tcnt_ff + 1'b1 : {CW{1'b0}};
			if (busy_o && tick)
				q_ff <= q_ff + 1'b1;
			case (st_ff)
				L_IDLE:
				begin
					q_ff <= 2'h0;
					if (cmd_valid_i)
					begin
						bit_ff  <= 4'h0;
						sh_ff   <= din_i;
						rd_ff   <= (cmd_i == `EPL_LNK_READ);
						mack_ff <= mack_i;
						if (cmd_i == `EPL_LNK_START)
							st_ff <= L_START;
						else if (cmd_i == `EPL_LNK_STOP)
							st_ff <= L_STOP;
						else
							st_ff <= L_BYTE;
					end
				end
				L_START:
				if (tick)
				begin
					// release data with clock high, then pull data low
					case (q_ff)
						2'h0:
						begin
							sda_oe_o <= 1'b0;
							scl_o    <= 1'b1;
						end
						2'h1: sda_oe_o <= 1'b1;
						default:
						begin
							scl_o  <= 1'b0;
							st_ff  <= L_IDLE;
							done_o <= 1'b1;
						end
					endcase
				end
				L_STOP:
				if (tick)
				begin
					case (q_ff)
						2'h0:
						begin
							scl_o    <= 1'b0;
							sda_oe_o <= 1'b1;
						end
						2'h1: scl_o <= 1'b1;
						default:
						begin
							sda_oe_o <= 1'b0;
							st_ff    <= L_IDLE;
							done_o   <= 1'b1;
						end
					endcase
				end
				L_BYTE:
				if (tick)
				begin
					// eight data bits msb first, then the acknowledge bit
					case (q_ff)
						2'h0:
						begin
							scl_o <= 1'b0;
							if (bit_ff != ACK_BIT)
								sda_oe_o <= ~rd_ff & ~sh_ff[7];
							else
								sda_oe_o <= rd_ff & mack_ff;
						end
						2'h1: scl_o <= 1'b1;
						2'h2:
						if (bit_ff != ACK_BIT)
							sh_ff <= {sh_ff[6:0], rd_ff & sda_s_ff};
						default:
						begin
							scl_o <= 1'b0;
							if (bit_ff == ACK_BIT)
							begin
								sda_oe_o <= 1'b0;
								st_ff    <= L_IDLE;
								done_o   <= 1'b1;
							end
							else
								bit_ff <= bit_ff + 1'b1;
						end
					endcase
				end
				default: st_ff <= L_IDLE;
			endcase
		end
	end
endmodule

/* File: epl_loader.v */
// Behaviour
// - page number is index bits 14..6
// - byte port moves one buffer byte
// - command 0 rewinds buffer pointer
// - command 1 loads page; not-ready meanwhile
// - command 2 burns buffer into page
// - key 0xA5 soft-resets all but the key detect
// - config checksum bit 0, load-done bit
// - code checksum result in bit 1
`timescale 1ns/1ps
`include "epl_regs.vh"
module epl_loader #(
	parameter TWR_CYC   = `EPL_TWR_CYC,
	parameter QTR_CYC   = `EPL_QTR_CYC,
	parameter FIFO_DPTH = 16,
	parameter FIFO_AW   = 4
) (
	input  wire       ref_clk_i,
	input  wire       resetn_i,
	input  wire       ce_i,
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	output reg        reg_rvalid_o,
	output reg        buf_wr_ready_o,
	output reg        soft_reset_o,
	output wire       scl_o,
	output wire       sda_o,
	output wire       sda_oe_o,
	input  wire       sda_i
);
	localparam [10:0] S_IDLE = 11'b000_0000_0001;
	localparam [10:0] S_ST   = 11'b000_0000_0010;
	localparam [10:0] S_DEVW = 11'b000_0000_0100;
	localparam [10:0] S_AHI  = 11'b000_0000_1000;
	localparam [10:0] S_ALO  = 11'b000_0001_0000;
	localparam [10:0] S_RST  = 11'b000_0010_0000;
	localparam [10:0] S_DEVR = 11'b000_0100_0000;
	localparam [10:0] S_RD   = 11'b000_1000_0000;
	localparam [10:0] S_WR   = 11'b001_0000_0000;
	localparam [10:0] S_STP  = 11'b010_0000_0000;
	localparam [10:0] S_WAIT = 11'b100_0000_0000;

	reg  [7:0]  buf_mem [0:63];
	reg  [10:0] st_ff;
	reg  [15:0] page_idx_ff;
	reg  [1:0]  cmd_ff;
	reg         pend_ff;
	reg         op_rd_ff;
	reg         boot_ff;
	reg         issued_ff;
	reg  [6:0]  idx_ff;
	reg  [5:0]  ptr_ff;
	reg  [8:0]  page_ff;
	reg  [22:0] twr_ff;
	reg  [7:0]  sum_cfg_ff;
	reg  [7:0]  sum_code_ff;
	reg         load_done_ff;
	reg  [1:0]  crc_ff;
	reg         srst_ff;
	reg         eng_go;
	reg  [1:0]  eng_cmd;
	reg  [7:0]  eng_din;
	wire        rst_n;
	wire        eng_busy;
	wire        eng_done;
	wire [7:0]  eng_dout;
	wire        last_byte;
	wire        wr_sel;
	wire        rd_sel;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire        fifo_out_ready;
	wire [7:0]  fifo_out_data;
	wire [FIFO_AW:0] fifo_level;
	wire        mem_ready;
	wire        start_ok;

	// register strobe decode, shared by all writes and the buffer port read
	function sel;
		input [7:0] addr;
		input [7:0] target;
		begin
			sel = (addr == target);
		end
	endfunction

	// key write resets everything on rst_n, one cycle later, but not the key detect, which only the pin reset clears
	assign rst_n     = resetn_i & ~srst_ff;
	assign last_byte = (idx_ff == `EPL_PAGE_BYTES - 7'h01);
	assign wr_sel    = reg_wr_i & sel(reg_addr_i, `EPL_ADDR_BUF_PORT);
	assign rd_sel    = reg_rd_i & sel(reg_addr_i, `EPL_ADDR_BUF_PORT);
	assign mem_ready = (st_ff == S_IDLE) & ~pend_ff & ~boot_ff;
	// commands wait for queued host bytes so the pointer order holds
	assign start_ok  = (st_ff == S_IDLE) & pend_ff & ~boot_ff & ~fifo_out_valid;
	// drain only while idle: a running transfer stalls the queue
	assign fifo_out_ready = (st_ff == S_IDLE) & ~boot_ff;

	epl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.in_valid_i  (wr_sel),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (reg_wdata_i),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data),
		.level_o     (fifo_level)
	);

	epl_link #(
		.QTR_CYC (QTR_CYC)
	) u_link (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.cmd_valid_i (eng_go),
		.cmd_i       (eng_cmd),
		.din_i       (eng_din),
		.mack_i      (~last_byte),
		.busy_o      (eng_busy),
		.done_o      (eng_done),
		.dout_o      (eng_dout),
		.scl_o       (scl_o),
		.sda_o       (sda_o),
		.sda_oe_o    (sda_oe_o),
		.sda_i       (sda_i)
	);

	// link command for the current step of the page transfer
	always @*
	begin
		eng_go  = ~issued_ff & ~eng_busy & (st_ff != S_IDLE) & (st_ff != S_WAIT);
		eng_cmd = `EPL_LNK_WRITE;
		eng_din = 8'h00;
		case (st_ff)
			S_ST:   eng_cmd = `EPL_LNK_START;
			S_RST:  eng_cmd = `EPL_LNK_START;
			S_STP:  eng_cmd = `EPL_LNK_STOP;
			S_RD:   eng_cmd = `EPL_LNK_READ;
			S_DEVW: eng_din = {`EPL_DEV_ADDR, 1'b0};
			S_DEVR: eng_din = {`EPL_DEV_ADDR, 1'b1};
			// byte address is page times 64, high byte first
			S_AHI:  eng_din = {1'b0, page_ff[8:2]};
			S_ALO:  eng_din = {page_ff[1:0], {`EPL_PAGE_LSB{1'b0}}};
			S_WR:   eng_din = buf_mem[idx_ff[5:0]];
			default: eng_din = 8'h00;
		endcase
	end

	// page buffer storage: queued host bytes and bytes read from memory
	always @(posedge ref_clk_i)
	begin
		if (ce_i)
		begin
			if (st_ff == S_RD && eng_done)
				buf_mem[idx_ff[5:0]] <= eng_dout;
			else if (fifo_out_valid && fifo_out_ready)
				buf_mem[ptr_ff] <= fifo_out_data;
		end
	end

	// register writes, command queue and buffer pointer
	always @(posedge ref_clk_i)
	begin
		if (!rst_n)
		begin
			page_idx_ff <= `EPL_PAGE_IDX_RST;
			cmd_ff      <= `EPL_CMD_RST;
			pend_ff     <= 1'b0;
			ptr_ff      <= 6'h00;
		end
		else if (ce_i)
		begin
			if (reg_wr_i && sel(reg_addr_i, `EPL_ADDR_PAGE_LO))
				page_idx_ff[7:0] <= reg_wdata_i;
			if (reg_wr_i && sel(reg_addr_i, `EPL_ADDR_PAGE_HI))
				page_idx_ff[15:8] <= reg_wdata_i;
			// pointer steps on each byte in or out, wraps inside the page
			if ((fifo_out_valid && fifo_out_ready) || rd_sel)
				ptr_ff <= ptr_ff + 6'h01;
			if (start_ok)
			begin
				pend_ff <= 1'b0;
				if (cmd_ff == `EPL_CMD_PTR_RST)
					ptr_ff <= 6'h00;
			end
			if (reg_wr_i && sel(reg_addr_i, `EPL_ADDR_MEM_CMD))
			begin
				cmd_ff <= reg_wdata_i[1:0];
				// reserved code leaves buffer, pointer and memory alone
				if (reg_wdata_i[1:0] != `EPL_CMD_RSVD)
					pend_ff <= 1'b1;
			end
		end
	end

	// page transfer sequencer over the serial link
	always @(posedge ref_clk_i)
	begin
		if (!rst_n)
		begin
			st_ff        <= S_IDLE;
			boot_ff      <= 1'b1;
			op_rd_ff     <= 1'b1;
			issued_ff    <= 1'b0;
			idx_ff       <= 7'h00;
			page_ff      <= `EPL_BOOT_PAGE;
			twr_ff       <= 23'h00_0000;
			sum_cfg_ff   <= 8'h00;
			sum_code_ff  <= 8'h00;
			load_done_ff <= 1'b0;
			crc_ff       <= 2'h0;
		end
		else if (ce_i)
		begin
			if (eng_go)
				issued_ff <= 1'b1;
			if (eng_done)
				issued_ff <= 1'b0;
			case (st_ff)
				S_IDLE:
				begin
					idx_ff <= 7'h00;
					// power-up load reads the boot page once after reset
					if (boot_ff && !load_done_ff)
					begin
						op_rd_ff <= 1'b1;
						st_ff    <= S_ST;
					end
					else if (start_ok && cmd_ff != `EPL_CMD_PTR_RST)
					begin
						op_rd_ff <= (cmd_ff == `EPL_CMD_LOAD);
						page_ff  <= page_idx_ff[`EPL_PAGE_MSB:`EPL_PAGE_LSB];
						st_ff    <= S_ST;
					end
				end
				S_ST:   if (eng_done) st_ff <= S_DEVW;
				S_DEVW: if (eng_done) st_ff <= S_AHI;
				S_AHI:  if (eng_done) st_ff <= S_ALO;
				S_ALO:  if (eng_done) st_ff <= op_rd_ff ? S_RST : S_WR;
				S_RST:  if (eng_done) st_ff <= S_DEVR;
				S_DEVR: if (eng_done) st_ff <= S_RD;
				S_RD:
				if (eng_done)
				begin
					// running sums: first half config, second half code
					if (idx_ff < `EPL_HALF_PAGE)
						sum_cfg_ff <= sum_cfg_ff + eng_dout;
					else
						sum_code_ff <= sum_code_ff + eng_dout;
					idx_ff <= idx_ff + 7'h01;
					if (last_byte)
						st_ff <= S_STP;
				end
				S_WR:
				if (eng_done)
				begin
					idx_ff <= idx_ff + 7'h01;
					if (last_byte)
						st_ff <= S_STP;
				end
				S_STP:
				if (eng_done)
				begin
					twr_ff <= 23'h00_0000;
					st_ff  <= op_rd_ff ? S_IDLE : S_WAIT;
					if (boot_ff)
					begin
						boot_ff      <= 1'b0;
						load_done_ff <= 1'b1;
						crc_ff[0]    <= (sum_cfg_ff == 8'h00);
						crc_ff[1]    <= (sum_code_ff == 8'h00);
					end
				end
				// memory busy with its internal write cycle
				S_WAIT:
				begin
					twr_ff <= twr_ff + 23'h00_0001;
					if (twr_ff == TWR_CYC[22:0] - 23'h00_0001)
						st_ff <= S_IDLE;
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	// key detect; survives its own reset so the pulse lasts one cycle
	always @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			srst_ff      <= 1'b0;
			soft_reset_o <= 1'b0;
		end
		else if (ce_i)
		begin
			srst_ff      <= reg_wr_i & sel(reg_addr_i, `EPL_ADDR_SRST_LOAD)
				& (reg_wdata_i == `EPL_SRST_KEY);
			soft_reset_o <= srst_ff;
		end
	end

	// read answers one cycle after the strobe; ready keeps one spare word
	always @(posedge ref_clk_i)
	begin
		if (!rst_n)
		begin
			reg_rdata_o    <= 8'h00;
			reg_rvalid_o   <= 1'b0;
			buf_wr_ready_o <= 1'b0;
		end
		else if (ce_i)
		begin
			reg_rvalid_o   <= reg_rd_i;
			buf_wr_ready_o <= fifo_in_ready
				& (fifo_level < FIFO_DPTH[FIFO_AW:0] - 1'b1);
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`EPL_ADDR_MEM_READY: reg_rdata_o <= {7'h00, mem_ready};
					`EPL_ADDR_PAGE_LO:   reg_rdata_o <= page_idx_ff[7:0];
					`EPL_ADDR_PAGE_HI:   reg_rdata_o <= page_idx_ff[15:8];
					`EPL_ADDR_BUF_PORT:  reg_rdata_o <= buf_mem[ptr_ff];
					`EPL_ADDR_MEM_CMD:   reg_rdata_o <= {6'h00, cmd_ff};
					`EPL_ADDR_SRST_LOAD: reg_rdata_o <= {7'h00, load_done_ff};
					`EPL_ADDR_LOAD_CRC:  reg_rdata_o <= {6'h00, crc_ff};
					default:             reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule

/* File: epl_mem_model.sv */
`timescale 1ns/1ps
module epl_mem_model (
	input  wire scl_i,
	input  wire sda_i,
	output reg  pull_o
);
	reg [7:0]  mem [0:32767];
	reg [7:0]  sh;
	reg [7:0]  tx;
	reg [3:0]  bitn;
	reg [1:0]  ph;
	reg [14:0] adr;
	reg        act;
	reg        rd;
	integer    k;
	// blank array, line released
	initial
	begin
		pull_o = 1'b0;
		act = 1'b0;
		rd = 1'b0;
		for (k = 0; k < 32768; k = k + 1)
			mem[k] = 8'h00;
	end
	// start: data falls while clock high; stop: data rises while clock high
	always @(negedge sda_i)
		if (scl_i)
		begin
			act = 1'b1;
			bitn = 4'hf;
			ph = 2'd0;
			rd = 1'b0;
		end
	always @(posedge sda_i)
		if (scl_i)
			act = 1'b0;
	// shift in on rising clock; a master nack ends the read burst
	always @(posedge scl_i)
		if (act && bitn < 4'h8)
			sh = {sh[6:0], sda_i};
		else if (act && rd && sda_i)
			act = 1'b0;
	// drive or release only while clock low, so no false start or stop
	always @(negedge scl_i)
		if (!act)
			pull_o = 1'b0;
		else
		begin
			bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
			if (bitn == 4'h8 && rd)
				pull_o = 1'b0;
			else if (bitn == 4'h8)
			begin
				pull_o = 1'b1;
				if (ph == 2'd0)
					rd = sh[0];
				else if (ph == 2'd1)
					adr[14:8] = sh[6:0];
				else if (ph == 2'd2)
					adr[7:0] = sh;
				else
				begin
					// page writes wrap inside the page
					mem[adr] = sh;
					adr[5:0] = adr[5:0] + 6'h01;
				end
				ph = (ph == 2'd3) ? ph : ph + 2'd1;
			end
			else if (rd)
			begin
				if (bitn == 4'h0)
				begin
					tx = mem[adr];
					adr = adr + 15'h0001;
				end
				pull_o = ~tx[3'h7 - bitn[2:0]];
			end
			else
				pull_o = 1'b0;
		end
endmodule

/* File: epl_loader_chk.sv */
`timescale 1ns/1ps
`include "epl_regs.vh"
module epl_loader_chk (
	input logic       ref_clk_i,
	input logic       resetn_i,
	input logic       ce_i,
	input logic [7:0] reg_addr_i,
	input logic       reg_wr_i,
	input logic       reg_rd_i,
	input logic [7:0] reg_wdata_i,
	input logic [7:0] reg_rdata_o,
	input logic       reg_rvalid_o,
	input logic       buf_wr_ready_o,
	input logic       soft_reset_o,
	input logic       scl_o,
	input logic       sda_o,
	input logic       sda_oe_o,
	input logic       sda_i
);
	// decoded strobes, only as taken by the register port
	wire rd_hit  = ce_i & reg_rd_i;
	wire key_hit = ce_i & reg_wr_i & (reg_addr_i == `EPL_ADDR_SRST_LOAD)
		& (reg_wdata_i == `EPL_SRST_KEY);
	wire cmd_hit = ce_i & reg_wr_i & (reg_addr_i == `EPL_ADDR_MEM_CMD)
		& (reg_wdata_i[1:0] != `EPL_CMD_RSVD);
	wire rdy_rd  = rd_hit & (reg_addr_i == `EPL_ADDR_MEM_READY);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	rvalid_follows_a: assert property ($past(ce_i) |-> reg_rvalid_o == $past(rd_hit))
		else $error("read valid does not follow read strobe");
	ready_bits_a: assert property (rdy_rd |=> reg_rdata_o[7:1] == 7'h00)
		else $error("ready read has stray bits");
	done_bits_a: assert property (rd_hit && reg_addr_i == `EPL_ADDR_SRST_LOAD |=> reg_rdata_o[7:1] == 7'h00)
		else $error("load done read has stray bits");
	crc_bits_a: assert property (rd_hit && reg_addr_i == `EPL_ADDR_LOAD_CRC |=> reg_rdata_o[7:2] == 6'h00)
		else $error("checksum read has stray bits");
	key_pulse_a: assert property (key_hit |-> ##2 soft_reset_o)
		else $error("key write gave no reset pulse");
	pulse_cause_a: assert property (soft_reset_o |-> $past(key_hit, 2))
		else $error("reset pulse without key write");
	pulse_single_a: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("reset pulse longer than one cycle");
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	scl_high_a: assert property ($rose(scl_o) |-> scl_o [*4])
		else $error("serial clock high phase too short");
	busy_after_cmd_a: assert property (cmd_hit ##1 rdy_rd |=> !reg_rdata_o[0])
		else $error("ready shown right after command");
	cover property (key_hit);
	cover property (cmd_hit ##1 rdy_rd);
	cover property ($rose(sda_oe_o));
endmodule
bind epl_loader epl_loader_chk u_chk (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.buf_wr_ready_o(buf_wr_ready_o), .soft_reset_o(soft_reset_o), .scl_o(scl_o),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .sda_i(sda_i)
);

/* File: epl_loader_tb.sv */
`timescale 1ns/1ps
`include "epl_regs.vh"
module epl_loader_tb;
	localparam LIMIT = 90000;
	reg        ref_clk_i   = 1'b0;
	reg        resetn_i    = 1'b0;
	reg        ce_i        = 1'b1;
	reg  [7:0] reg_addr_i  = 8'h00;
	reg        reg_wr_i    = 1'b0;
	reg        reg_rd_i    = 1'b0;
	reg  [7:0] reg_wdata_i = 8'h00;
	wire [7:0] reg_rdata_o;
	wire       reg_rvalid_o;
	wire       buf_wr_ready_o;
	wire       soft_reset_o;
	wire       scl_o;
	wire       sda_o;
	wire       sda_oe_o;
	wire       pull;
	integer    err_count   = 0;
	integer    cmp_count   = 0;
	integer    cyc         = 0;
	integer    seed        = 32'hbd97;
	integer    i;
	time       t_wr        = 0;
	time       t_rd        = 0;
	reg  [7:0] pg [0:63];
	reg  [7:0] rv;
	reg  [8:0] page;
	// open-drain line with pull-up: low if either party pulls
	wire       sda = (sda_oe_o | pull) ? sda_o : 1'b1;
	epl_loader #(
		.TWR_CYC(20),
		.QTR_CYC(4),
		.FIFO_DPTH(16),
		.FIFO_AW(4)
	) uut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.buf_wr_ready_o(buf_wr_ready_o), .soft_reset_o(soft_reset_o), .scl_o(scl_o),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .sda_i(sda)
	);
	epl_mem_model mem_u (.scl_i(scl_o), .sda_i(sda), .pull_o(pull));
	always #5 ref_clk_i = ~ref_clk_i;
	// hang guard, sized for six page transfers
	always @(posedge ref_clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == LIMIT)
		begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end
	task tally_and_finish;
	begin
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// bus tasks start and end on a falling edge so accesses go back to back
	// a strobe just lowered is not raised again in the same step: an edge passes first
	task wr(input [7:0] a, input [7:0] d);
	begin
		if (t_wr == $time)
			@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		t_wr = $time;
	end
	endtask
	task rd(input [7:0] a);
	begin
		if (t_rd == $time)
			@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		t_rd = $time;
		rv = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 8'hxx;
	end
	endtask
	task wait_bit(input [7:0] a);
	begin
		rd(a);
		while (rv[0] !== 1'b1)
			rd(a);
	end
	endtask
	task sel(input [8:0] p);
	begin
		wr(`EPL_ADDR_PAGE_LO, {p[1:0], 6'h00});
		wr(`EPL_ADDR_PAGE_HI, {1'b0, p[8:2]});
	end
	endtask
	task run_cmd(input [1:0] c);
	begin
		wr(`EPL_ADDR_MEM_CMD, {6'h00, c});
		rd(`EPL_ADDR_MEM_READY);
		chk(rv, 8'h00);
		wait_bit(`EPL_ADDR_MEM_READY);
	end
	endtask
	// stream the expected page into the buffer, obeying the queue flag
	task fill;
	begin
		for (i = 0; i < 64; i = i + 1)
		begin
			while (buf_wr_ready_o !== 1'b1)
				@(negedge ref_clk_i);
			wr(`EPL_ADDR_BUF_PORT, pg[i]);
		end
	end
	endtask
	task load_chk(input [8:0] p);
	begin
		sel(p);
		run_cmd(`EPL_CMD_PTR_RST);
		run_cmd(`EPL_CMD_LOAD);
		for (i = 0; i < 64; i = i + 1)
		begin
			rd(`EPL_ADDR_BUF_PORT);
			chk(rv, mem_u.mem[{p, i[5:0]}]);
		end
	end
	endtask
	function [7:0] sum8(input integer lo);
		integer k;
		begin
			sum8 = 8'h00;
			for (k = 0; k < 32; k = k + 1)
				sum8 = sum8 + pg[lo + k];
		end
	endfunction
	initial
	begin
		// boot page: config half sums to zero, code half does not
		for (i = 0; i < 64; i = i + 1)
			pg[i] = (i == 32) ? 8'h01 : 8'h00;
		#1;
		for (i = 0; i < 64; i = i + 1)
			mem_u.mem[i] = pg[i];
		repeat (2) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		wait_bit(`EPL_ADDR_SRST_LOAD);
		chk(rv, 8'h01);
		rd(`EPL_ADDR_LOAD_CRC);
		chk(rv, {6'h00, sum8(32) == 8'h00, sum8(0) == 8'h00});
		// reset values of index, port and command, then a reserved address
		for (i = 1; i < 6; i = i + 1)
		begin
			rd(8'hF0 + i[7:0]);
			chk(rv, 8'h00);
		end
		page = $random(seed) | 9'h001;
		sel(page);
		rd(`EPL_ADDR_PAGE_LO);
		chk(rv, {page[1:0], 6'h00});
		rd(`EPL_ADDR_PAGE_HI);
		chk(rv, {1'b0, page[8:2]});
		for (i = 0; i < 64; i = i + 1)
			pg[i] = $random(seed);
		run_cmd(`EPL_CMD_PTR_RST);
		fill;
		run_cmd(`EPL_CMD_BURN);
		for (i = 0; i < 64; i = i + 1)
			chk(mem_u.mem[{page, i[5:0]}], pg[i]);
		load_chk(9'h000);
		load_chk(page);
		// move the pointer off zero first, so the rewind has work to do
		rd(`EPL_ADDR_BUF_PORT);
		run_cmd(`EPL_CMD_PTR_RST);
		rd(`EPL_ADDR_BUF_PORT);
		chk(rv, pg[0]);
		// reserved code must leave pointer and ready alone
		wr(`EPL_ADDR_MEM_CMD, {6'h00, `EPL_CMD_RSVD});
		rd(`EPL_ADDR_MEM_READY);
		chk(rv, 8'h01);
		rd(`EPL_ADDR_BUF_PORT);
		chk(rv, pg[1]);
		// with the clock enable low a write must not land
		ce_i = 1'b0;
		wr(`EPL_ADDR_PAGE_LO, {~page[1:0], 6'h00});
		ce_i = 1'b1;
		rd(`EPL_ADDR_PAGE_LO);
		chk(rv, {page[1:0], 6'h00});
		chk({7'h00, buf_wr_ready_o}, 8'h01);
		// new boot page: config half fails, code half passes
		for (i = 0; i < 64; i = i + 1)
			pg[i] = $random(seed);
		pg[31] = pg[31] - sum8(0) + 8'h01;
		pg[63] = pg[63] - sum8(32);
		sel(9'h000);
		run_cmd(`EPL_CMD_PTR_RST);
		fill;
		run_cmd(`EPL_CMD_BURN);
		wr(`EPL_ADDR_PAGE_HI, 8'h7f);
		wr(`EPL_ADDR_SRST_LOAD, 8'h5a);
		rd(`EPL_ADDR_SRST_LOAD);
		chk(rv, 8'h01);
		wr(`EPL_ADDR_SRST_LOAD, `EPL_SRST_KEY);
		@(negedge ref_clk_i);
		chk({7'h00, soft_reset_o}, 8'h01);
		rd(`EPL_ADDR_SRST_LOAD);
		chk(rv, 8'h00);
		rd(`EPL_ADDR_PAGE_HI);
		chk(rv, 8'h00);
		wait_bit(`EPL_ADDR_SRST_LOAD);
		rd(`EPL_ADDR_LOAD_CRC);
		chk(rv, {6'h00, sum8(32) == 8'h00, sum8(0) == 8'h00});
		tally_and_finish;
	end
endmodule
